/* rtl/cptx_pkg.sv */
package cptx_pkg;
    // ==========================================================
    // Response decoding
    // ==========================================================
    // Response type codes as presented by the response decoder
    localparam logic [1:0] CPTX_RESP_PRE = 2'h1;
    localparam logic [1:0] CPTX_RESP_MID = 2'h2;
    localparam logic [1:0] CPTX_RESP_POST = 2'h3;
    localparam int CPTX_VEC_W = 8;
    localparam int CPTX_ADDR_W = 32;
    localparam int CPTX_MASK_W = 16;
    // Exception acknowledge mask value for the control interface register
    localparam logic [15:0] CPTX_ACK_MASK = 16'h0002;

    // ==========================================================
    // Stack frame sizes in 16-bit words
    // ==========================================================
    localparam logic [3:0] CPTX_FRAME_PRE = 4'h4;
    localparam logic [3:0] CPTX_FRAME_MID = 4'hA;
    localparam logic [3:0] CPTX_FRAME_POST = 4'h6;

    // Return behaviour after an unmodified frame
    typedef enum logic [1:0] {
        CPTX_RET_NONE,
        CPTX_RET_RESTART,
        CPTX_RET_RESUME,
        CPTX_RET_NEXT
    } cptx_ret_t;
endpackage

/* rtl/cptx_frame_sel.sv */
`timescale 1ns/1ps
// ==========================================================
// Frame selector: size and return kind from response type only
// ==========================================================
module cptx_frame_sel (
    input wire logic [1:0] resp_type,
    output logic [3:0] frame_words,
    output cptx_pkg::cptx_ret_t ret_kind
);
    import cptx_pkg::*;
    // Pure decode so the choice cannot depend on anything else
    assign frame_words = (resp_type == CPTX_RESP_PRE) ? CPTX_FRAME_PRE :
                         (resp_type == CPTX_RESP_MID) ? CPTX_FRAME_MID :
                         (resp_type == CPTX_RESP_POST) ? CPTX_FRAME_POST :
                         4'h0;
    assign ret_kind = (resp_type == CPTX_RESP_PRE) ? CPTX_RET_RESTART :
                      (resp_type == CPTX_RESP_MID) ? CPTX_RET_RESUME :
                      (resp_type == CPTX_RESP_POST) ? CPTX_RET_NEXT :
                      CPTX_RET_NONE;
endmodule

/* rtl/cptx_take_exc.sv */
`timescale 1ns/1ps
module cptx_take_exc (
    input wire logic ref_clk,
    input wire logic resetn,
    // Decoded response from the response interface register
    input wire logic resp_valid,
    input wire logic [1:0] resp_type,
    input wire logic [cptx_pkg::CPTX_VEC_W-1:0] resp_vector,
    input wire logic [cptx_pkg::CPTX_ADDR_W-1:0] opword_addr,
    input wire logic [cptx_pkg::CPTX_ADDR_W-1:0] scan_program_counter,
    input wire logic [cptx_pkg::CPTX_ADDR_W-1:0] eff_addr,
    input wire logic eff_addr_valid,
    // Control interface register write
    output logic ctrl_wr_req,
    output logic [cptx_pkg::CPTX_MASK_W-1:0] ctrl_wr_data,
    input wire logic ctrl_wr_done,
    // Request to the standard exception sequencer
    output logic exc_req,
    output logic [cptx_pkg::CPTX_VEC_W-1:0] exc_vector,
    output logic [3:0] exc_frame_words,
    output logic [cptx_pkg::CPTX_ADDR_W-1:0] exc_saved_pc,
    output logic [cptx_pkg::CPTX_ADDR_W-1:0] exc_saved_scan,
    output logic [cptx_pkg::CPTX_ADDR_W-1:0] exc_saved_ea,
    output logic exc_ea_defined,
    input wire logic exc_done,
    // Return from an unmodified frame
    input wire logic rte_req,
    output logic ret_valid,
    output cptx_pkg::cptx_ret_t ret_kind,
    output logic [cptx_pkg::CPTX_ADDR_W-1:0] ret_pc,
    output logic reread_resp,
    output logic busy
);
    import cptx_pkg::*;

    // ==========================================================
    // Reset release
    // ==========================================================
    logic rst_meta_ff;
    logic rst_sync_ff;
    // Async assert, two-flop release
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            rst_meta_ff <= 1'b0;
            rst_sync_ff <= 1'b0;
        end else begin
            rst_meta_ff <= 1'b1;
            rst_sync_ff <= rst_meta_ff;
        end
    end
    wire rst_n = rst_sync_ff;

    // ==========================================================
    // Sequencer
    // ==========================================================
    typedef enum logic [1:0] {
        CPTX_IDLE,
        CPTX_ACK,
        CPTX_EXC,
        CPTX_HOLD
    } cptx_state_t;

    cptx_state_t state_ff;
    cptx_state_t nxt_state;
    logic [1:0] type_ff;
    logic [CPTX_VEC_W-1:0] vec_ff;
    logic [CPTX_ADDR_W-1:0] pc_ff;
    logic [CPTX_ADDR_W-1:0] scan_ff;
    logic [CPTX_ADDR_W-1:0] ea_ff;
    logic ea_def_ff;
    logic [3:0] sel_words;
    cptx_ret_t sel_ret;

    cptx_frame_sel cptx_frame_sel_i (
        .resp_type(type_ff),
        .frame_words(sel_words),
        .ret_kind(sel_ret)
    );

    // Only the three exception responses are taken
    wire is_exc_resp = resp_valid && (resp_type == CPTX_RESP_PRE || resp_type == CPTX_RESP_MID ||
                                      resp_type == CPTX_RESP_POST);
    // A pre response right after a command write reports an earlier concurrent fault
    wire take = (state_ff == CPTX_IDLE) && is_exc_resp;

    // Next state: ack write strictly precedes the sequencer request
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            CPTX_IDLE: if (take) nxt_state = CPTX_ACK;
            CPTX_ACK: if (ctrl_wr_done) nxt_state = CPTX_EXC;
            CPTX_EXC: if (exc_done) nxt_state = CPTX_HOLD;
            CPTX_HOLD: if (rte_req) nxt_state = CPTX_IDLE;
            default: nxt_state = CPTX_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= CPTX_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // Capture context at receipt; scan PC is the value at that moment
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            type_ff <= 2'h0;
            vec_ff <= '0;
            pc_ff <= '0;
            scan_ff <= '0;
            ea_ff <= '0;
            ea_def_ff <= 1'b0;
        end else if (take) begin
            type_ff <= resp_type;
            vec_ff <= resp_vector;
            pc_ff <= opword_addr;
            scan_ff <= scan_program_counter;
            ea_ff <= eff_addr;
            ea_def_ff <= eff_addr_valid;
        end
    end

    // ==========================================================
    // Outputs
    // ==========================================================
    // Requests and busy are decoded from state, ret_valid from state and rte_req; data comes from captures, except the constant ack mask
    assign ctrl_wr_req = (state_ff == CPTX_ACK);
    assign ctrl_wr_data = CPTX_ACK_MASK;
    assign exc_req = (state_ff == CPTX_EXC);
    assign exc_vector = vec_ff;
    assign exc_frame_words = sel_words;
    assign exc_saved_pc = pc_ff;
    // Pre frame has no scan PC slot; zero it so nothing stale leaks
    assign exc_saved_scan = (type_ff == CPTX_RESP_PRE) ? '0 : scan_ff;
    // EA only meaningful in the mid frame and only if it was evaluated
    assign exc_ea_defined = ea_def_ff && (type_ff == CPTX_RESP_MID);
    assign exc_saved_ea = exc_ea_defined ? ea_ff : '0;
    assign ret_valid = (state_ff == CPTX_HOLD) && rte_req;
    assign ret_kind = sel_ret;
    // Restart at opcode word, or continue at scan PC
    assign ret_pc = (sel_ret == CPTX_RET_NEXT) ? scan_ff : pc_ff;
    assign reread_resp = ret_valid && (sel_ret == CPTX_RET_RESUME);
    assign busy = (state_ff != CPTX_IDLE);

    // ==========================================================
    // Checks
    // ==========================================================
    sequence s_taken;
        take;
    endsequence

    sequence s_ack_first;
        ctrl_wr_req && !exc_req;
    endsequence

    chk_ack_before_exc: assert property (@(posedge ref_clk) disable iff (!rst_n)
        s_taken |=> s_ack_first)
        else $error("ack mask not written before exception start");

    chk_no_exc_unacked: assert property (@(posedge ref_clk) disable iff (!rst_n)
        $rose(exc_req) |-> $past(ctrl_wr_req) && $past(ctrl_wr_done))
        else $error("exception started without ack completion");

    chk_vector_used: assert property (@(posedge ref_clk) disable iff (!rst_n)
        take |=> exc_vector == $past(resp_vector))
        else $error("vector differs from response field");

    chk_pre_frame: assert property (@(posedge ref_clk) disable iff (!rst_n)
        exc_req && type_ff == CPTX_RESP_PRE |-> exc_frame_words == CPTX_FRAME_PRE)
        else $error("pre frame not four words");

    chk_pre_restart: assert property (@(posedge ref_clk) disable iff (!rst_n)
        ret_valid && type_ff == CPTX_RESP_PRE |-> ret_pc == pc_ff && ret_kind == CPTX_RET_RESTART)
        else $error("pre return does not restart instruction");

    chk_mid_frame: assert property (@(posedge ref_clk) disable iff (!rst_n)
        exc_req && type_ff == CPTX_RESP_MID |-> exc_frame_words == CPTX_FRAME_MID)
        else $error("mid frame not ten words");

    chk_mid_scan: assert property (@(posedge ref_clk) disable iff (!rst_n)
        take && resp_type == CPTX_RESP_MID |=> exc_saved_scan == $past(scan_program_counter))
        else $error("mid frame scan value wrong");

    chk_mid_reread: assert property (@(posedge ref_clk) disable iff (!rst_n)
        ret_valid && type_ff == CPTX_RESP_MID |-> reread_resp)
        else $error("mid return does not reread response");

    chk_post_frame: assert property (@(posedge ref_clk) disable iff (!rst_n)
        exc_req && type_ff == CPTX_RESP_POST |-> exc_frame_words == CPTX_FRAME_POST)
        else $error("post frame not six words");

    chk_post_next: assert property (@(posedge ref_clk) disable iff (!rst_n)
        ret_valid && type_ff == CPTX_RESP_POST |-> ret_pc == scan_ff && !reread_resp)
        else $error("post return not at scan value");

    chk_exc_stays: assert property (@(posedge ref_clk) disable iff (!rst_n)
        exc_req && !exc_done |=> exc_req)
        else $error("exception request dropped early");

    chk_ret_by_type: assert property (@(posedge ref_clk) disable iff (!rst_n)
        busy && type_ff == CPTX_RESP_MID |-> ret_kind == CPTX_RET_RESUME)
        else $error("return kind not from response type");
endmodule

/* verification/cptx_copro_model.sv */
`timescale 1ns/1ps
// ==========================================================
// Far side: coprocessor control register and exception sequencer
// ==========================================================
module cptx_copro_model (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic [3:0] dly,
    input wire logic ctrl_wr_req,
    output logic ctrl_wr_done,
    input wire logic exc_req,
    output logic exc_done
);
    logic [3:0] ack_cnt_ff;
    logic [3:0] seq_cnt_ff;
    // One done pulse per request dly+1 cycles after it rises; slow answers exercise the waits
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            ack_cnt_ff <= 4'h0;
            seq_cnt_ff <= 4'h0;
            ctrl_wr_done <= 1'b0;
            exc_done <= 1'b0;
        end else begin
            ack_cnt_ff <= (ctrl_wr_req && !ctrl_wr_done) ? ack_cnt_ff + 4'h1 : 4'h0;
            seq_cnt_ff <= (exc_req && !exc_done) ? seq_cnt_ff + 4'h1 : 4'h0;
            ctrl_wr_done <= ctrl_wr_req && !ctrl_wr_done && ack_cnt_ff == dly;
            exc_done <= exc_req && !exc_done && seq_cnt_ff == dly;
        end
    end
endmodule

/* verification/cptx_take_exc_test.sv */
`timescale 1ns/1ps
module cptx_take_exc_test;
    import cptx_pkg::*;
    typedef struct {logic [31:0] vec, fw, pc, scan, ea, ead, rk, rpc, rr;} cptx_exp_t;
    logic ref_clk = 1'b0, resetn = 1'b0, resp_valid = 1'b0, eff_addr_valid = 1'b0, rte_req = 1'b0;
    logic [1:0] resp_type = 2'h0;
    logic [7:0] resp_vector = 8'h00;
    logic [31:0] opword_addr = 32'h0, scan_program_counter = 32'h0, eff_addr = 32'h0, seed = 32'h18;
    logic [3:0] dly = 4'h0;
    logic ctrl_wr_req, ctrl_wr_done, exc_req, exc_done, exc_ea_defined, ret_valid, reread_resp, busy, ack_ok = 1'b0;
    logic [15:0] ctrl_wr_data;
    logic [7:0] exc_vector;
    logic [3:0] exc_frame_words;
    logic [31:0] exc_saved_pc, exc_saved_scan, exc_saved_ea, ret_pc;
    cptx_ret_t ret_kind;
    cptx_exp_t q_exc[$], q_ret[$], e;
    int miscompares = 0, total_checks = 0;
    // ==========================================================
    // Clock, design and far side
    // ==========================================================
    always #20 ref_clk = ~ref_clk;
    cptx_take_exc cptx_take_exc_i (.ref_clk(ref_clk), .resetn(resetn), .resp_valid(resp_valid),
        .resp_type(resp_type), .resp_vector(resp_vector), .opword_addr(opword_addr),
        .scan_program_counter(scan_program_counter), .eff_addr(eff_addr), .eff_addr_valid(eff_addr_valid),
        .ctrl_wr_req(ctrl_wr_req), .ctrl_wr_data(ctrl_wr_data), .ctrl_wr_done(ctrl_wr_done), .exc_req(exc_req),
        .exc_vector(exc_vector), .exc_frame_words(exc_frame_words), .exc_saved_pc(exc_saved_pc),
        .exc_saved_scan(exc_saved_scan), .exc_saved_ea(exc_saved_ea), .exc_ea_defined(exc_ea_defined),
        .exc_done(exc_done), .rte_req(rte_req), .ret_valid(ret_valid), .ret_kind(ret_kind), .ret_pc(ret_pc),
        .reread_resp(reread_resp), .busy(busy));
    cptx_copro_model cptx_copro_model_i (.ref_clk(ref_clk), .resetn(resetn), .dly(dly),
        .ctrl_wr_req(ctrl_wr_req), .ctrl_wr_done(ctrl_wr_done), .exc_req(exc_req), .exc_done(exc_done));
    // ==========================================================
    // Helpers
    // ==========================================================
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d miscompares %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // One full exception: take, refused extra response, ack, frame, return
    task automatic take(input logic [1:0] t, input logic [7:0] v);
        cptx_exp_t x;
        int n;
        // A non-exception response first; it must be ignored
        @(posedge ref_clk);
        resp_valid <= 1'b1;
        resp_type <= 2'h0;
        @(posedge ref_clk);
        x.vec = v;
        x.pc = rnd();
        x.scan = rnd();
        x.ea = rnd();
        x.ead = {31'h0, x.ea[0]} & {31'h0, t == CPTX_RESP_MID};
        x.fw = (t == CPTX_RESP_PRE) ? CPTX_FRAME_PRE : (t == CPTX_RESP_MID) ? CPTX_FRAME_MID : CPTX_FRAME_POST;
        x.rk = (t == CPTX_RESP_PRE) ? CPTX_RET_RESTART : (t == CPTX_RESP_MID) ? CPTX_RET_RESUME : CPTX_RET_NEXT;
        x.rpc = (t == CPTX_RESP_POST) ? x.scan : x.pc;
        x.rr = {31'h0, t == CPTX_RESP_MID};
        q_exc.push_back(x);
        q_ret.push_back(x);
        resp_valid <= 1'b1;
        resp_type <= t;
        resp_vector <= v;
        opword_addr <= x.pc;
        scan_program_counter <= x.scan;
        eff_addr <= x.ea;
        eff_addr_valid <= x.ea[0];
        @(posedge ref_clk);
        check("busy_idle", {31'h0, busy}, 32'h0);
        resp_type <= CPTX_RESP_POST;
        x.scan = (t == CPTX_RESP_PRE) ? 32'h0 : x.scan;
        q_exc[$].scan = x.scan;
        @(posedge ref_clk);
        resp_valid <= 1'b0;
        check("busy_taken", {31'h0, busy}, 32'h1);
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (!exc_done && n < 60);
        check("exc_done_seen", {31'h0, exc_done}, 32'h1);
        rte_req <= 1'b1;
        @(posedge ref_clk);
        rte_req <= 1'b0;
    endtask
    // ==========================================================
    // Output watcher: pops the oldest note when a result appears
    // ==========================================================
    always @(posedge ref_clk) begin
        if (resetn) begin
            check("req_overlap", {31'h0, ctrl_wr_req & exc_req}, 32'h0);
            if (ctrl_wr_req && ctrl_wr_done) begin
                check("ack_mask", {16'h0, ctrl_wr_data}, {16'h0, CPTX_ACK_MASK});
                ack_ok = 1'b1;
            end
            if (exc_req && exc_done) begin
                check("ack_first", {31'h0, ack_ok}, 32'h1);
                ack_ok = 1'b0;
                if (q_exc.size() == 0) check("extra_exc", 32'h1, 32'h0);
                else begin
                    e = q_exc.pop_front();
                    check("vector", {24'h0, exc_vector}, e.vec);
                    check("frame_words", {28'h0, exc_frame_words}, e.fw);
                    check("saved_pc", exc_saved_pc, e.pc);
                    check("saved_scan", exc_saved_scan, e.scan);
                    check("ea_defined", {31'h0, exc_ea_defined}, e.ead);
                    check("saved_ea", exc_saved_ea, e.ead[0] ? e.ea : 32'h0);
                end
            end
            if (ret_valid) begin
                if (q_ret.size() == 0) check("extra_ret", 32'h1, 32'h0);
                else begin
                    e = q_ret.pop_front();
                    check("ret_kind", {30'h0, ret_kind}, e.rk);
                    check("ret_pc", ret_pc, e.rpc);
                    check("reread", {31'h0, reread_resp}, e.rr);
                end
            end
        end
    end
    // ==========================================================
    // Main sequence and watchdog
    // ==========================================================
    initial begin
        repeat (3) @(posedge ref_clk);
        resetn <= 1'b1;
        repeat (3) @(posedge ref_clk);
        // Pre with 11 as for an unknown command, mid with 13 as a protocol fault, post random
        for (int i = 0; i < 12; i++) begin
            logic [7:0] stim_vec;
            dly <= (i < 6) ? 4'h0 : 4'h3;
            stim_vec = (i % 3 == 0) ? 8'h0B : (i % 3 == 1) ? 8'h0D : 8'(rnd());
            // Pre only before visible changes; opword address stands for the noted one
            take(2'(i % 3 + 1), stim_vec);
        end
        repeat (4) @(posedge ref_clk);
        check("pending", q_exc.size() + q_ret.size(), 32'h0);
        print_verdict();
    end
    initial begin
        #(40 * 3000);
        miscompares++;
        print_verdict();
    end
endmodule
